// [logic/bsm_defs.vh]
`ifndef BSM_DEFS_VH
`define BSM_DEFS_VH
// APB byte offsets
`define BSM_OFS_CTRL 12'h000
`define BSM_OFS_CFG 12'h004
`define BSM_OFS_TEMPCFG 12'h008
`define BSM_OFS_INHCFG 12'h00c
`define BSM_OFS_SUSCFG 12'h010
`define BSM_OFS_OTTIME 12'h014
`define BSM_OFS_MEAS 12'h018
`define BSM_OFS_STATUS 12'h01c
`define BSM_OFS_TAPER 12'h020
`define BSM_OFS_HIB 12'h024
`define BSM_OFS_CAP 12'h028
// Control bit positions
`define BSM_CTRL_HIB_REQ 0
`define BSM_CTRL_OCV_START 1
// Config bit positions
`define BSM_CFG_TEMP_SRC 0
`define BSM_CFG_GND_SEL 1
`define BSM_CFG_REM_FULL 2
`define BSM_CFG_CHG_OPT 3
// Status bit positions
`define BSM_ST_OTC 0
`define BSM_ST_OTD 1
`define BSM_ST_INHIBIT 2
`define BSM_ST_SUSPEND 3
`define BSM_ST_CHARGING 4
`define BSM_ST_OCV_DONE 5
`define BSM_ST_OCV_BAD 6
`define BSM_ST_INIT_DONE 7
`define BSM_ST_PROF 8
`define BSM_ST_PRESENT 9
`define BSM_ST_MODE 10
// Reset values
`define BSM_CFG_RST 4'h1
// Poll interval: 1 s at 125 MHz
`define BSM_POLL_S 1
`define BSM_CLK_HZ 125000000
// Power modes
`define BSM_MODE_INSERT 2'h0
`define BSM_MODE_NORMAL 2'h1
`define BSM_MODE_HIB 2'h2
`endif

// [logic/bsm_monitor.v]
`timescale 1ns/1ps
`include "bsm_defs.vh"
module bsm_monitor #(
    parameter POLL_CYCLES = `BSM_POLL_S * `BSM_CLK_HZ
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Measurements, signed where relevant
    input wire signed [15:0] thermistor_temp,
    input wire signed [15:0] internal_temp,
    input wire signed [15:0] effective_current,
    input wire signed [15:0] average_current,
    input wire [15:0] cell_voltage,
    input wire [15:0] capacity_change,
    input wire [15:0] full_capacity,
    input wire taper_window_tick,
    input wire measure_done,
    input wire measure_valid,
    input wire [15:0] impedance_match,
    // Pins and system events
    input wire battery_insert_input,
    input wire host_addressed,
    input wire pack_known,
    // Outputs
    output reg battery_good_out,
    output reg adc_ground_select,
    output reg temp_source_select,
    output reg core_halt,
    output reg measure_start,
    output reg profile_copy,
    output reg profile_target,
    output reg [15:0] remaining_capacity
);
    // Register state
    reg [1:0] ctrl;
    reg [3:0] cfg;
    reg [31:0] tempcfg, inhcfg, suscfg, ottime, taper, hibcfg;
    reg [31:0] meas_dsg;
    reg charge_overtemp_flag, discharge_overtemp_flag;
    reg inhibit_flag, charge_suspend_flag, charging_flag;
    reg ocv_measure_done_flag, ocv_invalid_flag, init_done_flag;
    reg dynamic_profile_a_age, battery_present;
    reg [1:0] mode;
    reg [15:0] otc_cnt, otd_cnt;
    reg [1:0] taper_run;
    reg [31:0] poll_cnt;
    reg [1:0] init_step;
    localparam INIT_IDLE = 2'h0;
    localparam INIT_OCV = 2'h1;
    localparam INIT_IMP = 2'h2;

    // Temperature source choice
    wire signed [15:0] temp = cfg[`BSM_CFG_TEMP_SRC] ? thermistor_temp : internal_temp;
    wire signed [15:0] ot_chg = tempcfg[15:0];
    wire signed [15:0] ot_chg_rec = tempcfg[31:16];
    wire signed [15:0] ot_dsg = meas_dsg[15:0];
    wire signed [15:0] ot_dsg_rec = meas_dsg[31:16];
    wire signed [15:0] inh_lo = inhcfg[15:0];
    wire signed [15:0] inh_hi = inhcfg[31:16];
    wire signed [15:0] sus_lo = suscfg[15:0];
    wire signed [15:0] sus_hi = suscfg[31:16];
    wire signed [15:0] hys = {8'h00, taper[31:24]};
    wire signed [15:0] chg_thr = {8'h00, taper[23:16]};
    wire signed [15:0] dsg_thr = {8'h00, hibcfg[31:24]};
    wire [15:0] otc_time = ottime[15:0];
    wire [15:0] otd_time = ottime[31:16];
    wire in_window = (temp >= inh_lo + hys) && (temp <= inh_hi - hys);

    // APB access, zero wait states
    wire wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr > `BSM_OFS_CAP);
    wire [31:0] status = {20'h00000, mode, battery_present, dynamic_profile_a_age,
        init_done_flag, ocv_invalid_flag, ocv_measure_done_flag, charging_flag,
        charge_suspend_flag, inhibit_flag, discharge_overtemp_flag, charge_overtemp_flag};
    always @* begin
        case (paddr)
            `BSM_OFS_CTRL: prdata = {30'h00000000, ctrl};
            `BSM_OFS_CFG: prdata = {28'h0000000, cfg};
            `BSM_OFS_TEMPCFG: prdata = tempcfg;
            `BSM_OFS_INHCFG: prdata = inhcfg;
            `BSM_OFS_SUSCFG: prdata = suscfg;
            `BSM_OFS_OTTIME: prdata = ottime;
            `BSM_OFS_MEAS: prdata = meas_dsg;
            `BSM_OFS_STATUS: prdata = status;
            `BSM_OFS_TAPER: prdata = taper;
            `BSM_OFS_HIB: prdata = hibcfg;
            `BSM_OFS_CAP: prdata = {16'h0000, remaining_capacity};
            default: prdata = 32'h00000000;
        endcase
    end

    // Config registers
    always @(posedge clock) begin
        if (rst) begin
            ctrl <= 2'h0;
            cfg <= `BSM_CFG_RST;
            tempcfg <= 32'h00000000;
            inhcfg <= 32'h00000000;
            suscfg <= 32'h00000000;
            ottime <= 32'h00000000;
            meas_dsg <= 32'h00000000;
            taper <= 32'h00000000;
            hibcfg <= 32'h00000000;
        end else begin
            if (wr && paddr == `BSM_OFS_CTRL)
                ctrl <= pwdata[1:0];
            else if (init_step == INIT_OCV)
                ctrl[`BSM_CTRL_OCV_START] <= 1'b0; // Start bit self-clears
            if (wr && paddr == `BSM_OFS_CFG) cfg <= pwdata[3:0];
            if (wr && paddr == `BSM_OFS_TEMPCFG) tempcfg <= pwdata;
            if (wr && paddr == `BSM_OFS_INHCFG) inhcfg <= pwdata;
            if (wr && paddr == `BSM_OFS_SUSCFG) suscfg <= pwdata;
            if (wr && paddr == `BSM_OFS_OTTIME) ottime <= pwdata;
            if (wr && paddr == `BSM_OFS_MEAS) meas_dsg <= pwdata;
            if (wr && paddr == `BSM_OFS_TAPER) taper <= pwdata;
            if (wr && paddr == `BSM_OFS_HIB) hibcfg <= pwdata;
        end
    end

    // Source and ground selects to converter
    always @(posedge clock) begin
        if (rst) begin
            temp_source_select <= 1'b1;
            adc_ground_select <= 1'b0;
        end else begin
            temp_source_select <= cfg[`BSM_CFG_TEMP_SRC];
            adc_ground_select <= cfg[`BSM_CFG_GND_SEL];
        end
    end

    // Overtemp qualification; timers restart on any break
    wire otc_cond = charging_flag && temp >= ot_chg && effective_current > chg_thr;
    wire otd_cond = !charging_flag && temp >= ot_dsg && effective_current <= -dsg_thr;
    always @(posedge clock) begin
        if (rst) begin
            otc_cnt <= 16'h0000;
            otd_cnt <= 16'h0000;
            charge_overtemp_flag <= 1'b0;
            discharge_overtemp_flag <= 1'b0;
        end else begin
            if (otc_time == 16'h0000) begin
                otc_cnt <= 16'h0000;
                charge_overtemp_flag <= 1'b0;
            end else begin
                if (!otc_cond)
                    otc_cnt <= 16'h0000;
                else if (otc_cnt != otc_time)
                    otc_cnt <= otc_cnt + 16'h0001;
                if (otc_cond && otc_cnt == otc_time)
                    charge_overtemp_flag <= 1'b1;
                else if (temp <= ot_chg_rec)
                    charge_overtemp_flag <= 1'b0;
            end
            if (otd_time == 16'h0000) begin
                otd_cnt <= 16'h0000;
                discharge_overtemp_flag <= 1'b0;
            end else begin
                if (!otd_cond)
                    otd_cnt <= 16'h0000;
                else if (otd_cnt != otd_time)
                    otd_cnt <= otd_cnt + 16'h0001;
                if (otd_cond && otd_cnt == otd_time)
                    discharge_overtemp_flag <= 1'b1;
                else if (temp <= ot_dsg_rec)
                    discharge_overtemp_flag <= 1'b0;
            end
        end
    end

    // Charge termination over two taper windows
    wire taper_ok = effective_current < $signed({8'h00, taper[7:0]}) &&
        capacity_change > {8'h00, taper[15:8]};
    wire volt_ok = cell_voltage > hibcfg[15:0];
    wire terminate = taper_window_tick && taper_ok && taper_run == 2'h1 && volt_ok;
    always @(posedge clock) begin
        if (rst) begin
            taper_run <= 2'h0;
            charging_flag <= 1'b0;
            remaining_capacity <= 16'h0000;
        end else begin
            if (taper_window_tick)
                taper_run <= taper_ok ? 2'h1 : 2'h0;
            if (terminate) begin
                charging_flag <= 1'b0;
                taper_run <= 2'h0;
                if (cfg[`BSM_CFG_REM_FULL])
                    remaining_capacity <= full_capacity;
            end else if (effective_current > chg_thr) begin
                charging_flag <= 1'b1;
            end else if (effective_current <= -dsg_thr) begin
                charging_flag <= 1'b0; // Discharge ends charging, else DISCHARGE_OVERTEMP_FLAG never arms
            end
            if (wr && paddr == `BSM_OFS_CAP)
                remaining_capacity <= pwdata[15:0];
        end
    end

    // Inhibit and suspend windows with hysteresis
    always @(posedge clock) begin
        if (rst) begin
            inhibit_flag <= 1'b0;
            charge_suspend_flag <= 1'b0;
        end else begin
            if (temp < inh_lo || temp > inh_hi)
                inhibit_flag <= 1'b1;
            else if (in_window)
                inhibit_flag <= 1'b0;
            if (!cfg[`BSM_CFG_CHG_OPT])
                charge_suspend_flag <= 1'b0;
            else if (temp < sus_lo || temp > sus_hi)
                charge_suspend_flag <= 1'b1;
            else if (in_window)
                charge_suspend_flag <= 1'b0;
        end
    end

    // Insertion poll, once a second; low means present
    always @(posedge clock) begin
        if (rst) begin
            poll_cnt <= 32'h00000000;
            battery_present <= 1'b0;
        end else if (poll_cnt == POLL_CYCLES - 1) begin
            poll_cnt <= 32'h00000000;
            battery_present <= !battery_insert_input;
        end else begin
            poll_cnt <= poll_cnt + 32'h00000001;
        end
    end

    // Power mode and initialisation sequence
    wire abs_low = (average_current < 0 ? -average_current : average_current) <
        $signed({8'h00, hibcfg[23:16]});
    always @(posedge clock) begin
        if (rst) begin
            mode <= `BSM_MODE_INSERT;
            init_step <= INIT_IDLE;
            core_halt <= 1'b1;
            battery_good_out <= 1'b0;
            measure_start <= 1'b0;
            profile_copy <= 1'b0;
            profile_target <= 1'b0;
            dynamic_profile_a_age <= 1'b0;
            ocv_measure_done_flag <= 1'b0;
            ocv_invalid_flag <= 1'b0;
            init_done_flag <= 1'b0;
        end else begin
            measure_start <= 1'b0;
            profile_copy <= 1'b0;
            case (mode)
                `BSM_MODE_INSERT: begin
                    core_halt <= !host_addressed;
                    if (battery_present) begin
                        mode <= `BSM_MODE_NORMAL;
                        init_step <= INIT_OCV;
                        measure_start <= 1'b1;
                        battery_good_out <= 1'b0;
                        core_halt <= 1'b0;
                    end
                end
                `BSM_MODE_NORMAL: begin
                    core_halt <= 1'b0;
                    if (!battery_present) begin
                        mode <= `BSM_MODE_INSERT;
                        battery_good_out <= 1'b0;
                        init_done_flag <= 1'b0;
                    end else if ((ctrl[`BSM_CTRL_HIB_REQ] && ocv_measure_done_flag &&
                            !ocv_invalid_flag && abs_low) || cell_voltage < hibcfg[15:0] -
                            {8'h00, taper[31:24]}) begin
                        mode <= `BSM_MODE_HIB;
                        battery_good_out <= 1'b0;
                        core_halt <= 1'b1;
                    end else if (init_done_flag) begin
                        battery_good_out <= !inhibit_flag;
                    end
                    if (ctrl[`BSM_CTRL_OCV_START] && init_step == INIT_IDLE) begin
                        init_step <= INIT_OCV;
                        measure_start <= 1'b1;
                    end
                    case (init_step)
                        INIT_OCV: if (measure_done) begin
                            ocv_measure_done_flag <= 1'b1;
                            ocv_invalid_flag <= !measure_valid;
                            init_step <= init_done_flag ? INIT_IDLE : INIT_IMP;
                        end
                        INIT_IMP: begin
                            battery_good_out <= !inhibit_flag;
                            if (!pack_known) begin
                                profile_copy <= 1'b1;
                                profile_target <= dynamic_profile_a_age;
                                dynamic_profile_a_age <= !dynamic_profile_a_age;
                            end
                            init_done_flag <= |impedance_match || 1'b1;
                            init_step <= INIT_IDLE;
                        end
                        default: ;
                    endcase
                end
                `BSM_MODE_HIB: begin
                    core_halt <= 1'b1;
                    if (host_addressed) begin
                        mode <= `BSM_MODE_NORMAL;
                        init_step <= INIT_OCV;
                        init_done_flag <= 1'b0;
                        measure_start <= 1'b1;
                        core_halt <= 1'b0;
                    end
                end
                default: mode <= `BSM_MODE_NORMAL;
            endcase
        end
    end
endmodule

// [sim/bsm_monitor_props.sv]
`timescale 1ns/1ps
`include "bsm_defs.vh"
module bsm_monitor_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Levels and outputs
    input wire logic signed [15:0] thermistor_temp,
    input wire logic signed [15:0] internal_temp,
    input wire logic pack_known,
    input wire logic battery_good_out,
    input wire logic adc_ground_select,
    input wire logic temp_source_select,
    input wire logic measure_start,
    input wire logic profile_copy
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [31:0] cfg_q;
    logic [31:0] inh_q;
    logic inh_set;
    wire acc = psel && penable && pready;
    wire cfg_hit = acc && pwrite && paddr == `BSM_OFS_CFG;
    wire signed [15:0] t_now = temp_source_select ? thermistor_temp : internal_temp;
    wire t_out = inh_set && (t_now < $signed(inh_q[15:0]) || t_now > $signed(inh_q[31:16]));
    // Shadow host writes; thresholds unknown until written
    always @(posedge clock) begin
        if (rst) begin
            inh_set <= 1'b0;
        end else if (acc && pwrite) begin
            if (paddr == `BSM_OFS_CFG) begin
                cfg_q <= pwdata;
            end
            if (paddr == `BSM_OFS_INHCFG) begin
                inh_q <= pwdata;
                inh_set <= 1'b1;
            end
        end
    end
    sequence cfg_settled;
        cfg_hit ##1 !cfg_hit;
    endsequence
    sequence temp_outside;
        t_out [*3];
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc |-> pslverr == (paddr > `BSM_OFS_CAP))
        else $error("pslverr wrong");
    a_unmapped_zero: assert property (acc && !pwrite && paddr > `BSM_OFS_CAP |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_src_follows: assert property (cfg_settled |=> temp_source_select == cfg_q[0])
        else $error("source select wrong");
    a_gnd_follows: assert property (cfg_settled |=> adc_ground_select == cfg_q[1])
        else $error("ground select wrong");
    a_start_pulse: assert property (measure_start |=> !measure_start)
        else $error("start pulse too long");
    a_copy_pulse: assert property (profile_copy |=> !profile_copy)
        else $error("copy pulse too long");
    a_copy_unknown: assert property (profile_copy |-> !$past(pack_known))
        else $error("copy on known pack");
    a_inhibit_low: assert property (temp_outside |-> !battery_good_out)
        else $error("battery good outside window");
endmodule
bind bsm_monitor bsm_monitor_props i_props (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .thermistor_temp(thermistor_temp),
    .internal_temp(internal_temp), .pack_known(pack_known),
    .battery_good_out(battery_good_out), .adc_ground_select(adc_ground_select),
    .temp_source_select(temp_source_select), .measure_start(measure_start),
    .profile_copy(profile_copy));

// [sim/bsm_meas_model.sv]
`timescale 1ns/1ps
module bsm_meas_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request, settings, reply
    input wire logic start,
    input wire logic good,
    input wire logic [3:0] lag,
    output logic done,
    output logic valid
);
    int cnt;
    // Conversion ends lag+1 cycles after start; valid is junk outside done
    always @(posedge clock) begin
        done <= 1'b0;
        valid <= ~valid;
        if (rst) begin
            cnt <= 0;
            valid <= 1'b0;
        end else if (start) begin
            cnt <= lag + 1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                done <= 1'b1;
                valid <= good;
            end
        end
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "bsm_defs.vh"
module testbench;
    localparam int POLL = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic signed [15:0] therm = 16'sd25, itemp = 16'sd25, eff = 16'sd0, avg = 16'sd0;
    logic [15:0] volt = 16'h1068, dcap = 16'h0, fcap = 16'h04d2, imp = 16'h0;
    logic tick = 1'b0, ins = 1'b1, hit = 1'b0, known = 1'b0, good = 1'b1;
    logic [3:0] lag = 4'h2;
    wire pready, pslverr, done, valid, bgood, gsel, tsel, halt, mstart, pcopy, ptgt;
    wire [31:0] prdata;
    wire [15:0] rcap;
    logic [63:0] notes[$];
    logic [63:0] note;
    int fail_count = 0;
    int cmp_count = 0;
    int r;
    bsm_monitor #(.POLL_CYCLES(POLL)) i_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .thermistor_temp(therm), .internal_temp(itemp),
        .effective_current(eff), .average_current(avg), .cell_voltage(volt),
        .capacity_change(dcap), .full_capacity(fcap), .taper_window_tick(tick),
        .measure_done(done), .measure_valid(valid), .impedance_match(imp),
        .battery_insert_input(ins), .host_addressed(hit), .pack_known(known),
        .battery_good_out(bgood), .adc_ground_select(gsel), .temp_source_select(tsel),
        .core_halt(halt), .measure_start(mstart), .profile_copy(pcopy),
        .profile_target(ptgt), .remaining_capacity(rcap));
    bsm_meas_model i_meas (.clock(clock), .rst(rst), .start(mstart), .good(good), .lag(lag),
        .done(done), .valid(valid));
    // Clock
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic finish_test;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One transfer; psel stays up so the next may follow at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] m = 32'hffffffff);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) notes.push_back({m, d & m});
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    // Read data taken at the edge completing the access
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite) begin
            note = notes.pop_front();
            check(prdata & note[63:32], note[31:0]);
        end
    end
    // Watchdog against hangs
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        finish_test;
    end
    initial begin
        r = $urandom(76860);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        imp <= 16'($urandom);
        @(posedge clock);
        check(halt, 1'b1);
        apb(0, `BSM_OFS_CFG, 32'h1, 32'hf);
        apb(0, 12'h02c, 32'h0);
        apb(1, 12'h040, 32'hffffffff);
        apb(0, 12'h040, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1, `BSM_OFS_CFG, i);
            apb(0, `BSM_OFS_CFG, i, 32'hf);
            check(tsel, i[0]);
            check(gsel, i[1]);
        end
        apb(1, `BSM_OFS_CFG, 32'h5);
        apb(1, `BSM_OFS_INHCFG, 32'h0032fff6);
        apb(1, `BSM_OFS_SUSCFG, 32'h003cffec);
        apb(1, `BSM_OFS_TAPER, 32'h030a0514);
        apb(1, `BSM_OFS_HIB, 32'h0a320fa0);
        apb(1, `BSM_OFS_OTTIME, 32'h00050005);
        apb(1, `BSM_OFS_TEMPCFG, 32'h0028002d);
        apb(1, `BSM_OFS_MEAS, 32'h0028002d);
        lag <= 4'($urandom_range(9));
        ins <= 1'b0;
        idle(1);
        for (int i = 0; i < POLL + 4 && mstart !== 1'b1; i++) @(posedge clock);
        check(mstart, 1'b1);
        for (int i = 0; i < 40 && bgood !== 1'b1; i++) @(posedge clock);
        check(bgood, 1'b1);
        idle(4);
        check(halt, 1'b0);
        check(ptgt, 1'b0);
        apb(0, `BSM_OFS_STATUS, 32'h7a0, 32'hfe0);
        // Host-started voltage reading, failing then passing
        for (int k = 0; k < 2; k++) begin
            good <= k[0];
            apb(1, `BSM_OFS_CTRL, 32'h2);
            idle(16);
            apb(0, `BSM_OFS_STATUS, k ? 32'h20 : 32'h60, 32'h60);
        end
        // Hot without option, hot and cold with suspend option
        for (int k = 0; k < 3; k++) begin
            r = $urandom_range(8);
            apb(1, `BSM_OFS_CFG, k ? 32'hd : 32'h5);
            therm <= 16'(k == 0 ? 51 + r : (k == 1 ? 61 + r : -21 - r));
            idle(4);
            check(bgood, 1'b0);
            apb(0, `BSM_OFS_STATUS, k ? 32'hc : 32'h4, 32'hc);
            therm <= 16'(k == 2 ? -8 : 48);
            idle(4);
            check(bgood, 1'b0);
            apb(0, `BSM_OFS_STATUS, k ? 32'hc : 32'h4, 32'hc);
            therm <= 16'sd25;
            idle(4);
            check(bgood, 1'b1);
            apb(0, `BSM_OFS_STATUS, 32'h0, 32'hc);
        end
        // Charge then discharge over-temperature
        for (int k = 0; k < 2; k++) begin
            eff <= k ? -16'sd50 : 16'sd50;
            therm <= 16'sd46;
            idle(3);
            therm <= 16'sd30;
            idle(1);
            therm <= 16'sd46;
            idle(3);
            apb(0, `BSM_OFS_STATUS, 32'h0, 32'h3);
            idle(8);
            apb(0, `BSM_OFS_STATUS, k ? 32'h2 : 32'h1, 32'h3);
            therm <= 16'sd40;
            idle(3);
            apb(0, `BSM_OFS_STATUS, 32'h0, 32'h3);
            apb(1, `BSM_OFS_OTTIME, 32'h0);
            therm <= 16'sd46;
            idle(12);
            apb(0, `BSM_OFS_STATUS, 32'h0, 32'h3);
            apb(1, `BSM_OFS_OTTIME, 32'h00050005);
            therm <= 16'sd25;
        end
        eff <= 16'sd10;
        dcap <= 16'h8;
        fcap <= 16'($urandom);
        apb(1, `BSM_OFS_CAP, 32'h7);
        for (int k = 0; k < 2; k++) begin
            tick <= 1'b1;
            idle(1);
            tick <= 1'b0;
            idle(3);
            check(rcap, k ? fcap : 16'h7);
        end
        apb(0, `BSM_OFS_STATUS, 32'h0, 32'h10);
        avg <= 16'sd100;
        apb(1, `BSM_OFS_CTRL, 32'h1);
        idle(4);
        apb(0, `BSM_OFS_STATUS, 32'h400, 32'hc00);
        avg <= -16'sd30;
        idle(4);
        apb(0, `BSM_OFS_STATUS, 32'h800, 32'hc00);
        apb(1, `BSM_OFS_CTRL, 32'h0);
        idle(4);
        apb(0, `BSM_OFS_STATUS, 32'h800, 32'hc00);
        hit <= 1'b1;
        known <= 1'b1;
        idle(1);
        hit <= 1'b0;
        idle(16);
        apb(0, `BSM_OFS_STATUS, 32'h500, 32'hd00);
        volt <= 16'd3990;
        idle(4);
        apb(0, `BSM_OFS_STATUS, 32'h800, 32'hc00);
        idle(2);
        finish_test;
    end
endmodule
